// ==== hdl/hpmc_top.sv ====
// Port mode, forwarding and equalizer control of a four-input camera hub.
// Assumes reset_i comes from the power-down pin, rx streams and the
// register port are on clock_i, lock, strap and reference clock are not.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps

module hpmc_top
   import hpmc_pkg::*;
(
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic [7:0]            reg_wdata_i,
   input  wire logic                  reg_write_i,
   input  wire logic                  reg_read_i,
   output logic      [7:0]            reg_rdata_o,
   input  wire logic                  reference_clock_input_i,
   input  wire logic [2:0]            mode_strap_i,
   input  wire logic [3:0]            lock_i,
   input  wire hpmc_word_s [3:0]      rx_word_i,
   output logic      [3:0]            rx_ready_o,
   output hpmc_word_s [1:0]           tx_word_o,
   output logic      [3:0][1:0]       receive_format_select_o,
   output logic      [3:0]            cable_type_select_o,
   output logic      [3:0]            eq_restart_o,
   output logic      [3:0]            eq_adapt_o,
   output logic      [7:0]            eq_floor_o,
   output logic                       reference_clock_input_lost_o,
   output logic                       irq_o
);

   // Decodes a strap level into a receive format.
   function automatic logic [1:0] strap_format(input logic [2:0] level);
      case (level[1:0])
         2'h1:    strap_format = FMT_TWELVE_BIT_LOW_FREQ_FORMAT;
         2'h2:    strap_format = FMT_TWELVE_BIT_HIGH_FREQ_FORMAT;
         2'h3:    strap_format = FMT_RAW10;
         default: strap_format = FMT_RESERVED;
      endcase
   endfunction

   // Round-robin pick: first request after the last grant.
   function automatic logic [2:0] pick(input logic [3:0] req,
                                       input logic [1:0] last);
      logic [1:0] idx;
      pick = 3'h0;
      for (int i = 1; i <= 4; i++)
      begin
         idx = 2'(last + 2'(i));
         if (req[idx] && !pick[2])
         begin
            pick = {1'b1, idx};
         end
      end
   endfunction

   logic [3:0]       lock_meta;        // First synchroniser stage.
   logic [3:0]       lock_sync;        // Lock as seen by the logic.
   logic [3:0]       lock_prev;        // Delayed copy for edges.
   logic             ref_meta;         // First reference clock stage.
   logic             ref_sync;         // Synchronised reference clock.
   logic             ref_prev;         // Delayed copy for edges.
   logic [2:0]       strap_meta;       // First strap stage.
   logic [2:0]       strap_sync;       // Synchronised strap level.
   hpmc_strap_e      strap_state;      // Strap loader state.
   logic [1:0]       port_sel;         // Port that paged registers show.
   logic [1:0]       vc [4];           // Channel per receive port.
   logic [5:0]       dt [4];           // Data type per receive port.
   logic [3:0]       dest;             // Transmit port per receive port.
   logic [3:0]       fwd_en;           // Forwarding enable per port.
   logic             replicate;        // Second port copies the first.
   logic [3:0]       adapt_en;         // Equalizer adaptation enable.
   logic [3:0]       restart_cnt [4];  // Reference edges left.
   logic [7:0]       restart_count [4];// Restarts seen per port.
   logic [GAP_W-1:0] ref_gap;          // Cycles since last ref edge.
   logic [4:0]       irq_status;       // Sticky event bits.
   logic [4:0]       irq_mask;         // Event enables.
   logic [1:0]       grant_valid;      // Transmit port owns a packet.
   logic [1:0]       grant_port [2];   // Owner; last owner for one idle cycle, then 0.

   logic             wr_cfg;           // Port config write.
   logic             strap_load;       // Strap defaults load now.
   logic [3:0]       lock_fall;        // Lock lost this cycle.
   logic             ref_rise;         // Reference clock rising edge.
   logic [3:0]       force_restart;    // Software restart request.
   logic [4:0]       events;           // Interrupt sources.
   logic [7:0]       rd_value;         // Read data before the flop.
   logic [3:0]       take;             // Receive byte accepted.
   logic [3:0]       held;             // Port owned by some transmitter.
   logic [1:0]       next_grant_valid;
   logic [1:0]       next_grant_port [2];
   logic [3:0]       next_ready;
   hpmc_word_s [1:0] next_tx;

   // Two-stage synchronisers; only the second stage feeds logic.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         lock_meta  <= 4'h0;
         lock_sync  <= 4'h0;
         lock_prev  <= 4'h0;
         ref_meta   <= 1'b0;
         ref_sync   <= 1'b0;
         ref_prev   <= 1'b0;
         strap_meta <= 3'h0;
         strap_sync <= 3'h0;
      end
      else
      begin
         lock_meta  <= lock_i;
         lock_sync  <= lock_meta;
         lock_prev  <= lock_sync;
         ref_meta   <= reference_clock_input_i;
         ref_sync   <= ref_meta;
         ref_prev   <= ref_sync;
         strap_meta <= mode_strap_i;
         strap_sync <= strap_meta;
      end
   end

   assign lock_fall = lock_prev & ~lock_sync;
   assign ref_rise  = ref_sync & ~ref_prev;
   assign wr_cfg    = reg_write_i && (reg_addr_i == ADDR_PORT_CFG);

   // Strap loader waits out the synchroniser, then loads once.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         strap_state <= ST_SYNC;
      end
      else
      begin
         case (strap_state)
            ST_SYNC:   strap_state <= ST_SETTLE;
            ST_SETTLE: strap_state <= ST_LOAD;
            ST_LOAD:   strap_state <= ST_DONE;
            ST_DONE:   strap_state <= ST_DONE;
            default:   strap_state <= ST_SYNC;
         endcase
      end
   end

   assign strap_load = (strap_state == ST_LOAD);

   // Per-port format and cable. A write in the load cycle wins, so
   // software keeps an override made in that cycle; a write before it is lost to the strap.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         receive_format_select_o <= {4{RST_FORMAT}};
         cable_type_select_o     <= 4'h0;
      end
      else
      begin
         for (int p = 0; p < 4; p++)
         begin
            if (wr_cfg && (port_sel == 2'(p)))
            begin
               receive_format_select_o[p] <= reg_wdata_i[1:0];
               cable_type_select_o[p] <= reg_wdata_i[CFG_CABLE_BIT];
            end
            else if (strap_load)
            begin
               receive_format_select_o[p] <= strap_format(strap_sync);
               cable_type_select_o[p] <= strap_sync[2];
            end
         end
      end
   end

   // Stream identity and forwarding controls, paged by port_sel.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         port_sel   <= 2'h0;
         dest       <= 4'h0;
         fwd_en     <= 4'h0;
         replicate  <= 1'b0;
         adapt_en   <= 4'hF;
         eq_floor_o <= RST_EQ_FLOOR;
         irq_mask   <= 5'h00;
         for (int p = 0; p < 4; p++)
         begin
            vc[p] <= 2'(p);
            dt[p] <= RST_DT;
         end
      end
      else if (reg_write_i)
      begin
         case (reg_addr_i)
            ADDR_PORT_SEL:  port_sel <= reg_wdata_i[1:0];
            ADDR_STREAM_ID:
            begin
               vc[port_sel] <= reg_wdata_i[7:6];
               dt[port_sel] <= reg_wdata_i[5:0];
            end
            ADDR_FWD_CTRL:
            begin
               dest[port_sel]   <= reg_wdata_i[FWD_DEST_BIT];
               fwd_en[port_sel] <= reg_wdata_i[FWD_EN_BIT];
            end
            ADDR_GLOBAL:    replicate <= reg_wdata_i[GLB_REPL_BIT];
            ADDR_EQ_CTRL:   adapt_en <= reg_wdata_i[3:0];
            ADDR_EQ_FLOOR:  eq_floor_o <= reg_wdata_i;
            ADDR_IRQ_MASK:  irq_mask <= reg_wdata_i[4:0];
            default:        port_sel <= port_sel;
         endcase
      end
   end

   // Upper bits of an equalizer control write kick a restart.
   assign force_restart = (reg_write_i && reg_addr_i == ADDR_EQ_CTRL) ?
                          reg_wdata_i[7:4] : 4'h0;

   // Reference clock watch: edges pace restarts, a long gap is lost.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ref_gap       <= '0;
         reference_clock_input_lost_o <= 1'b0;
      end
      else
      begin
         if (ref_rise)
         begin
            ref_gap <= '0;
         end
         else if (ref_gap != REFERENCE_CLOCK_INPUT_STOP_CYC)
         begin
            ref_gap <= ref_gap + 1'b1;
         end
         reference_clock_input_lost_o <= (ref_gap == REFERENCE_CLOCK_INPUT_STOP_CYC);
      end
   end

   // Equalizer restart runs a fixed number of reference edges so the
   // restart length follows the reference, not the system clock.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         eq_restart_o <= 4'h0;
         eq_adapt_o   <= 4'h0;
         for (int p = 0; p < 4; p++)
         begin
            restart_cnt[p]   <= 4'h0;
            restart_count[p] <= 8'h00;
         end
      end
      else
      begin
         for (int p = 0; p < 4; p++)
         begin
            if (lock_fall[p] || force_restart[p])
            begin
               restart_cnt[p]  <= EQ_RESTART_EDGES;
               eq_restart_o[p] <= 1'b1;
               if (restart_count[p] != 8'hFF)
               begin
                  restart_count[p] <= restart_count[p] + 8'h01;
               end
            end
            else if (eq_restart_o[p] && ref_rise)
            begin
               restart_cnt[p] <= restart_cnt[p] - 4'h1;
               if (restart_cnt[p] == 4'h1)
               begin
                  eq_restart_o[p] <= 1'b0;
               end
            end
            // Adaptation tracks drift while the port is locked, enabled and not restarting.
            eq_adapt_o[p] <= adapt_en[p] & lock_sync[p] &
                             ~eq_restart_o[p];
         end
      end
   end

   // Sticky events; a read clears, an event in that cycle survives.
   assign events = {(ref_gap == REFERENCE_CLOCK_INPUT_STOP_CYC) & ~reference_clock_input_lost_o,
                    lock_fall};

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         irq_status <= 5'h00;
         irq_o      <= 1'b0;
      end
      else
      begin
         if (reg_read_i && reg_addr_i == ADDR_IRQ_STAT)
         begin
            irq_status <= events;
         end
         else
         begin
            irq_status <= irq_status | events;
         end
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // Read decode; unmapped offsets read zero.
   always_comb
   begin
      case (reg_addr_i)
         ADDR_PORT_SEL:  rd_value = {6'h00, port_sel};
         ADDR_PORT_CFG:  rd_value = {5'h00, cable_type_select_o[port_sel],
                                     receive_format_select_o[port_sel]};
         ADDR_STREAM_ID: rd_value = {vc[port_sel], dt[port_sel]};
         ADDR_FWD_CTRL:  rd_value = {6'h00, fwd_en[port_sel],
                                     dest[port_sel]};
         ADDR_GLOBAL:    rd_value = {7'h00, replicate};
         ADDR_IRQ_STAT:  rd_value = {3'h0, irq_status};
         ADDR_IRQ_MASK:  rd_value = {3'h0, irq_mask};
         ADDR_EQ_CTRL:   rd_value = {4'h0, adapt_en};
         ADDR_EQ_STAT:   rd_value = {eq_restart_o, lock_sync};
         ADDR_EQ_FLOOR:  rd_value = eq_floor_o;
         ADDR_EQ_COUNT:  rd_value = restart_count[port_sel];
         default:        rd_value = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         reg_rdata_o <= reg_read_i ? rd_value : 8'h00;
      end
   end

   // Packet arbiters. Ownership is per packet so streams interleave
   // only at packet boundaries; an unlocked port loses ownership.
   always_comb
   begin
      logic [3:0] elig;
      logic [2:0] choice;
      logic [1:0] gp;
      elig   = 4'h0;
      choice = 3'h0;
      gp     = 2'h0;
      held   = 4'h0;
      for (int p = 0; p < 4; p++)
      begin
         take[p] = rx_word_i[p].valid & rx_ready_o[p] &
                   lock_sync[p];
      end
      for (int t = 0; t < 2; t++)
      begin
         if (grant_valid[t])
         begin
            held[grant_port[t]] = 1'b1;
         end
      end
      next_ready = 4'h0;
      for (int t = 0; t < 2; t++)
      begin
         gp                   = grant_port[t];
         next_grant_valid[t]  = grant_valid[t];
         next_grant_port[t]   = gp;
         for (int p = 0; p < 4; p++)
         begin
            elig[p] = lock_sync[p] & fwd_en[p] & ~held[p] &
                      rx_word_i[p].valid & rx_word_i[p].first &
                      ((replicate ? 1'b0 : dest[p]) == t[0]);
         end
         if (grant_valid[t])
         begin
            if ((take[gp] && rx_word_i[gp].last) || !lock_sync[gp] ||
                !fwd_en[gp])
            begin
               next_grant_valid[t] = 1'b0;
            end
         end
         else
         begin
            choice = pick(elig, gp);
            next_grant_valid[t] = choice[2];
            next_grant_port[t]  = choice[1:0];
         end
         if (next_grant_valid[t])
         begin
            next_ready[next_grant_port[t]] = 1'b1;
         end
      end
   end

   // Header byte gets the port's channel; image types get its type.
   always_comb
   begin
      logic [1:0] gp;
      gp      = 2'h0;
      next_tx = '0;
      for (int t = 0; t < 2; t++)
      begin
         gp = grant_port[t];
         if (grant_valid[t] && take[gp])
         begin
            next_tx[t] = rx_word_i[gp];
            if (rx_word_i[gp].first)
            begin
               next_tx[t].data[7:6] = vc[gp];
               if (rx_word_i[gp].data[5:0] >= DT_IMAGE_FIRST)
               begin
                  next_tx[t].data[5:0] = dt[gp];
               end
            end
         end
      end
   end

   // Output stage. Each transmit port feeds up to four lanes
   // outside this block; replication copies the first port.
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         grant_valid   <= 2'h0;
         grant_port[0] <= 2'h0;
         grant_port[1] <= 2'h0;
         rx_ready_o    <= 4'h0;
         tx_word_o     <= '0;
      end
      else
      begin
         grant_valid   <= next_grant_valid;
         grant_port[0] <= next_grant_port[0];
         grant_port[1] <= next_grant_port[1];
         rx_ready_o    <= next_ready;
         tx_word_o[0]  <= next_tx[0];
         tx_word_o[1]  <= replicate ? next_tx[0] : next_tx[1];
      end
   end

   // Checks on the logic above.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   a_strap_load: assert property (
      $rose(strap_state == ST_DONE) && !$past(wr_cfg) |->
      receive_format_select_o[0] == strap_format($past(strap_sync)))
      else $error("strap format not loaded");

   a_fmt_write: assert property (
      wr_cfg && port_sel == 2'h1 |=>
      receive_format_select_o[1] == $past(reg_wdata_i[1:0]))
      else $error("format write lost");

   a_cable_write: assert property (
      wr_cfg && port_sel == 2'h2 |=>
      cable_type_select_o[2] == $past(reg_wdata_i[CFG_CABLE_BIT]))
      else $error("cable write lost");

   a_unlock_quiet: assert property (
      !lock_sync[0] |=> !rx_ready_o[0])
      else $error("unlocked port still ready");

   a_lock_restart: assert property (
      $fell(lock_sync[3]) |=> eq_restart_o[3] ##1 !eq_adapt_o[3])
      else $error("no equalizer restart on lock loss");

   a_vc_stamp: assert property (
      take[0] && rx_word_i[0].first && grant_valid[0] &&
      grant_port[0] == 2'h0 |=> tx_word_o[0].data[7:6] == $past(vc[0]))
      else $error("channel not inserted");

   a_sync_kept: assert property (
      take[1] && rx_word_i[1].first && rx_word_i[1].data[5:0] < 6'h10
      && grant_valid[0] && grant_port[0] == 2'h1 |=>
      tx_word_o[0].data[5:0] == $past(rx_word_i[1].data[5:0]))
      else $error("sync packet type altered");

   a_replicate_copy: assert property (
      $past(replicate) |-> tx_word_o[1] == tx_word_o[0])
      else $error("replica differs");

   a_route_second: assert property (
      take[2] && !replicate && dest[2] && grant_valid[1] &&
      grant_port[1] == 2'h2 |=> tx_word_o[1].valid)
      else $error("stream not routed to second port");

   a_reference_clock_input_stop: assert property (
      ref_gap == REFERENCE_CLOCK_INPUT_STOP_CYC - 9'h001 && !ref_rise |=>
      ##1 reference_clock_input_lost_o)
      else $error("reference stop not flagged");

   a_irq_level: assert property (
      ##1 irq_o == $past(|(irq_status & irq_mask)))
      else $error("interrupt level wrong");

   // A status read keeps only the events of its own cycle.
   a_irq_clear: assert property (
      reg_read_i && reg_addr_i == ADDR_IRQ_STAT |=>
      irq_status == $past(events))
      else $error("status read did not clear");

endmodule // hpmc_top

// ==== hdl/hpmc_pkg.sv ====
// Shared constants and types of the camera hub port mode block.
// Assumes one 20 MHz system clock and an 8-bit register port.
package hpmc_pkg;

   // Register offsets.
   localparam logic [7:0] ADDR_PORT_SEL  = 8'h4C;
   localparam logic [7:0] ADDR_PORT_CFG  = 8'h6D;
   localparam logic [7:0] ADDR_STREAM_ID = 8'h70;
   localparam logic [7:0] ADDR_FWD_CTRL  = 8'h71;
   localparam logic [7:0] ADDR_GLOBAL    = 8'h72;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h73;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h74;
   localparam logic [7:0] ADDR_EQ_CTRL   = 8'hD2;
   localparam logic [7:0] ADDR_EQ_STAT   = 8'hD3;
   localparam logic [7:0] ADDR_EQ_FLOOR  = 8'hD4;
   localparam logic [7:0] ADDR_EQ_COUNT  = 8'hD5;

   // Field positions.
   localparam int CFG_CABLE_BIT  = 2;
   localparam int FWD_DEST_BIT   = 0;
   localparam int FWD_EN_BIT     = 1;
   localparam int GLB_REPL_BIT   = 0;
   localparam int IRQ_REFERENCE_CLOCK_INPUT_BIT = 4;

   // Receive formats as held in the port configuration field.
   typedef enum logic [1:0] {
      FMT_TWELVE_BIT_LOW_FREQ_FORMAT = 2'h0,
      FMT_TWELVE_BIT_HIGH_FREQ_FORMAT = 2'h1,
      FMT_RAW10    = 2'h2,
      FMT_RESERVED = 2'h3
   } hpmc_format_e;

   // Strap loader states.
   typedef enum logic [1:0] {
      ST_SYNC   = 2'h0,
      ST_SETTLE = 2'h1,
      ST_LOAD   = 2'h2,
      ST_DONE   = 2'h3
   } hpmc_strap_e;

   // Reset values.
   localparam logic [1:0] RST_FORMAT   = 2'h2;
   localparam logic [5:0] RST_DT       = 6'h2B;
   localparam logic [7:0] RST_EQ_FLOOR = 8'h00;

   // Data types below this pass through untouched (sync, embedded).
   localparam logic [5:0] DT_IMAGE_FIRST = 6'h18;

   // Timing: reference clock stop limit and equalizer restart length.
   localparam int CLK_PERIOD_NS  = 50;
   localparam int REFERENCE_CLOCK_INPUT_STOP_NS = 20000;
   localparam int GAP_W          = 9;
   localparam logic [GAP_W-1:0] REFERENCE_CLOCK_INPUT_STOP_CYC = GAP_W'(
      (REFERENCE_CLOCK_INPUT_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] EQ_RESTART_EDGES = 4'h4;

   // One byte of a packet stream with framing flags.
   typedef struct packed {
      logic       valid;
      logic       first;
      logic       last;
      logic [7:0] data;
   } hpmc_word_s;

endpackage

// ==== tb/hpmc_cam.sv ====
// Camera model: sends a two-byte packet on a receive port per go pulse.
// Assumes ready is registered on clock_i and lock is held by the bench.
`timescale 1ns/10ps
module hpmc_cam
   import hpmc_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       go_i,
   input  wire logic [7:0] hdr_i,
   input  wire logic       ready_i,
   output hpmc_word_s      word_o
);
   initial word_o = '0;
   // A byte stands until ready; idle data toggles so stale bytes never pass.
   always @(posedge clock_i)
   begin
      if (go_i && !word_o.valid)
         word_o <= '{1'b1, 1'b1, 1'b0, hdr_i};
      else if (word_o.valid && ready_i)
         word_o <= '{!word_o.last, 1'b0, !word_o.last, word_o.data ^ 8'h5A};
      else if (!word_o.valid)
         word_o.data <= ~word_o.data;
   end
endmodule // hpmc_cam

// ==== tb/hpmc_top_bench.sv ====
// Self-checking bench of the camera hub port mode block.
// Assumes the camera model is compiled before it.
`timescale 1ns/10ps
module hpmc_top_bench;
   import hpmc_pkg::*;
   logic clock_i = 0, reset_i = 1, reg_write_i = 0, reg_read_i = 0, irq_o;
   logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, d, r, h;
   logic reference_clock_input = 0, run_ref = 1, lost;
   logic [3:0] adapt;
   logic [7:0] floor;
   logic [2:0] mode_strap_i = '0, lvl;
   logic [3:0] lock_i = 4'hF, go = '0, rx_ready_o, eq_restart_o, cab_o;
   hpmc_word_s [3:0] rx_word_i;
   hpmc_word_s [1:0] tx_word_o;
   logic [3:0][1:0] fmt_o;
   logic [7:0] hdr_q [2];
   int n_q [2] = '{0, 0};
   int n_errors = 0, comparisons = 0, p, t, c0, c1;

   always #25 clock_i = ~clock_i;
   // The reference clock runs until a scenario stops it on purpose.
   always #200 if (run_ref) reference_clock_input = ~reference_clock_input;

   hpmc_top dut (.clock_i(clock_i), .reset_i(reset_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o), .reference_clock_input_i(reference_clock_input),
      .mode_strap_i(mode_strap_i), .lock_i(lock_i), .rx_word_i(rx_word_i),
      .rx_ready_o(rx_ready_o), .tx_word_o(tx_word_o),
      .receive_format_select_o(fmt_o), .cable_type_select_o(cab_o),
      .eq_restart_o(eq_restart_o), .eq_adapt_o(adapt), .eq_floor_o(floor),
      .reference_clock_input_lost_o(lost), .irq_o(irq_o));

   for (genvar i = 0; i < 4; i++)
   begin : g_cam
      hpmc_cam cam (.clock_i(clock_i), .go_i(go[i]), .hdr_i(h),
                    .ready_i(rx_ready_o[i]), .word_o(rx_word_i[i]));
   end

   // Counts bytes leaving each transmit port and keeps the last header.
   always @(posedge clock_i)
      for (int i = 0; i < 2; i++)
         if (tx_word_o[i].valid === 1'b1)
         begin
            n_q[i] <= n_q[i] + 1;
            if (tx_word_o[i].first)
               hdr_q[i] <= tx_word_o[i].data;
         end

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      // An idle edge keeps the strobe from being driven twice in one step.
      reg_write_i <= 1'b0;
      @(posedge clock_i);
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      @(negedge clock_i);
      v = reg_rdata_o;
      @(posedge clock_i);
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // A fixed wait covers the take, the stamp and both bytes.
   task automatic send(input int q, input logic [7:0] hd);
      h <= hd;
      go[q] <= 1'b1;
      @(posedge clock_i);
      go[q] <= 1'b0;
      repeat (30) @(posedge clock_i);
   endtask

   task automatic end_sim;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #500000;
      n_errors++;
      end_sim();
   end

   initial
   begin
      void'($urandom(10872));
      lvl = 3'($urandom);
      mode_strap_i <= lvl;
      repeat (5) @(posedge clock_i);
      reset_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      // A later strap change must not reach the fields.
      mode_strap_i <= ~lvl;
      repeat (4) @(posedge clock_i);
      for (p = 0; p < 4; p++)
      begin
         wr(ADDR_PORT_SEL, 8'(p));
         rd(ADDR_PORT_CFG, r);
         chk(r & 8'h07, 8'({lvl[2], lvl[1:0] - 2'h1}));
         chk(8'({fmt_o[p], cab_o[p]}), 8'({lvl[1:0] - 2'h1, lvl[2]}));
         d = 8'($urandom % 8);
         wr(ADDR_PORT_CFG, d);
         rd(ADDR_PORT_CFG, r);
         chk(r & 8'h07, d);
         chk(8'({fmt_o[p], cab_o[p]}), 8'({d[1:0], d[2]}));
      end
      rd(8'h00, r);
      chk(r, 8'h00);
      // Stream from every port; ports 0 and 1 to the first transmit
      // port, ports 2 and 3 to the second, with random identities.
      for (p = 0; p < 4; p++)
      begin
         t = p / 2;
         d = 8'($urandom);
         wr(ADDR_PORT_SEL, 8'(p));
         wr(ADDR_STREAM_ID, d);
         wr(ADDR_FWD_CTRL, 8'(2 + t));
         c0 = n_q[1 - t];
         c1 = n_q[t];
         send(p, 8'h2A ^ 8'($urandom % 4 << 6));
         chk(hdr_q[t], d);
         chk(8'(n_q[t] - c1), 8'h02);
         send(p, 8'hC1);
         chk(hdr_q[t], {d[7:6], 6'h01});
         chk(8'(n_q[1 - t] - c0), 8'h00);
      end
      p = 3;
      // Replicate mode: the second port copies the first.
      wr(ADDR_GLOBAL, 8'h01);
      c1 = n_q[1];
      send(p, 8'h2A);
      chk(hdr_q[0], d);
      chk(hdr_q[1], d);
      chk(8'(n_q[1] - c1), 8'h02);
      wr(ADDR_EQ_FLOOR, d);
      rd(ADDR_EQ_FLOOR, r);
      chk(r, d);
      chk(floor, d);
      // Lock loss: masked first, then unmasked, then cleared by a read.
      wr(ADDR_IRQ_MASK, 8'h00);
      lock_i[p] <= 1'b0;
      repeat (6) @(posedge clock_i);
      chk(8'(eq_restart_o[p]), 8'h01);
      chk(8'(adapt[p]), 8'h00);
      chk(8'(irq_o), 8'h00);
      wr(ADDR_IRQ_MASK, 8'h0F);
      repeat (2) @(posedge clock_i);
      chk(8'(irq_o), 8'h01);
      c0 = n_q[0];
      send(p, 8'h2A);
      chk(8'(n_q[0] - c0), 8'h00);
      rd(ADDR_IRQ_STAT, r);
      chk(r & 8'h1F, 8'(1 << p));
      rd(ADDR_EQ_COUNT, r);
      chk(r, 8'h01);
      wr(ADDR_EQ_CTRL, 8'h1F);
      chk(8'(eq_restart_o[0]), 8'h01);
      repeat (2) @(posedge clock_i);
      chk(8'(irq_o), 8'h00);
      lock_i[p] <= 1'b1;
      repeat (10) @(posedge clock_i);
      // A stopped reference is flagged; the controller then resets the
      // part, which reloads the strap that now stands on the pins.
      run_ref <= 1'b0;
      repeat (420) @(posedge clock_i);
      chk(8'(lost), 8'h01);
      rd(ADDR_IRQ_STAT, r);
      chk(r & 8'h1F, 8'h10);
      reset_i <= 1'b1;
      run_ref <= 1'b1;
      repeat (5) @(posedge clock_i);
      reset_i <= 1'b0;
      repeat (6) @(posedge clock_i);
      chk(8'(lost), 8'h00);
      rd(ADDR_PORT_CFG, r);
      chk(r & 8'h07, 8'({~lvl[2], ~lvl[1:0] - 2'h1}));
      end_sim();
   end
endmodule // hpmc_top_bench
